// ### src/gated_sixteen_bit_timer.sv
// Gated 16-bit timer/counter with prescaler, gate control and rollover interrupt.
//
// Overview of operation
// R1: Sixteen-bit count from two bytes; wrap from all ones sets rollover flag.
// R2: Clock source select: 1 external rising edges, 0 instruction clock.
// R3: Sync disable skips synchronised behaviour externally; ignored for internal clock. Here it only lets the external count run in sleep; pins stay synchronised.
// R4: Prescale field divides input by one, two, four or eight.
// R5: Prescale counter is hidden; any count byte write clears it.
// R6: Timer on bit lets counting happen; cleared it stops the counter.
// R7: With timer on, gate enable restricts counting to gate-true periods.
// R8: Gate polarity picks high-true or low-true for either gate source.
// R9: Gate source is gate pin or comparator two output, chosen by bit.
// R10: Counter mode needs a falling edge before the first counted rising edge.
// R11: Oscillator enable runs low-power clock only when system clock allows it.
// R12: Unsynchronised counter mode keeps counting during sleep and can wake.
// R13: Interrupt needs all three enables; flag stays until software clears.
// R14: Software should clear count and flag before enabling interrupts.
// R15: Software should stop the timer before writing the count bytes.
// R16: Gate, count and oscillator inputs pass two flip-flops before use.
`include "timer_cfg.svh"

module gated_sixteen_bit_timer (
    input  wire logic                CLK,
    input  wire logic                ARST_N,
    input  wire logic [`ADDR_W-1:0]  ADDR,
    input  wire logic [7:0]          WDATA,
    input  wire logic                WR,
    input  wire logic                RD,
    output logic      [7:0]          RDATA,
    input  wire logic                EXT_COUNT_IN,
    input  wire logic                GATE_PIN,
    input  wire logic                COMP_TWO_OUT,
    input  wire logic                LP_OSC_IN,
    input  wire logic                LP_OSC_ALLOWED,
    input  wire logic                SLEEP,
    output logic                     LP_OSC_RUN,
    output logic                     IRQ,
    output logic                     WAKE
);

    // Reset release: asynchronous assert, two-stage synchronous release.
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Pin synchronisers; the first stage feeds only the second.
    // All four pins are asynchronous to the system clock, whichever mode is chosen.
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [3:0] pin_raw;

    assign pin_raw = {LP_OSC_IN, COMP_TWO_OUT, GATE_PIN, EXT_COUNT_IN};

    // R16 two-stage synchronisers
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge CLK or negedge rst_n) begin
                if (!rst_n) begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    // Software-visible state.
    timer_pkg::timer_control_s ctrl;
    logic [15:0]               count;
    logic                      rollover_flag;
    logic                      rollover_irq_enable;
    logic                      peripheral_irq_enable;
    logic                      global_irq_enable;
    logic [7:0]                comparator_two_control;

    // Address decode. Offset 0 holds the control byte, and 1 and 2 the count bytes.
    // Offset 3 is the sticky status, which a read clears, and offset 4 is its mask.
    // Offset 5 holds the peripheral enable in bit 0 and the global enable in bit 1.
    // Offset 6 holds the gate source select in bit 1, and offset 7 shows live state.
    // Writes to the status and live-state offsets are ignored on purpose.
    wire wr_ctrl   = WR && (ADDR == `OFS_TIMER_CONTROL);
    wire wr_low    = WR && (ADDR == `OFS_COUNT_LOW_BYTE);
    wire wr_high   = WR && (ADDR == `OFS_COUNT_HIGH_BYTE);
    wire wr_mask   = WR && (ADDR == `OFS_IRQ_MASK);
    wire wr_global = WR && (ADDR == `OFS_IRQ_GLOBAL);
    wire wr_comp   = WR && (ADDR == `OFS_COMP_TWO_CONTROL);
    wire rd_status = RD && (ADDR == `OFS_IRQ_STATUS);
    wire wr_count  = wr_low || wr_high;

    // R11 low-power oscillator only where the system clock shares it
    wire lp_osc_eff = ctrl.lp_osc_enable && LP_OSC_ALLOWED;
    assign LP_OSC_RUN = lp_osc_eff;

    // The external path takes the oscillator when it runs, else the count pin.
    // Changing the oscillator enable while counting can show one false edge here,
    // so software should stop the timer before it switches the source.
    wire ext_level = lp_osc_eff ? pin_sync[3] : pin_sync[0];

    // R9 gate source selection
    wire gate_raw  = comparator_two_control[`BIT_GATE_SOURCE_SEL] ? pin_sync[2] : pin_sync[1];
    // R8 gate polarity
    wire gate_true = ctrl.gate_polarity ? gate_raw : ~gate_raw;

    // R6 R7 on bit and gate qualify counting
    wire run_enable = ctrl.timer_on && (!ctrl.gate_enable || gate_true);

    // R3 R12 only the unsynchronised counter keeps going in sleep
    wire async_mode = ctrl.clock_source_select && ctrl.sync_disable;
    wire awake_ok   = !SLEEP || async_mode;

    // Instruction clock phase: one tick in every four system clocks.
    // The phase runs free from reset and no write restarts it, so a fresh start
    // may wait up to four clocks for its first tick.
    logic [1:0] instr_phase;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            instr_phase <= 2'h0;
        end else begin
            instr_phase <= instr_phase + 2'h1;
        end
    end

    wire instr_tick = (instr_phase == 2'(`INSTR_DIV - 1));

    // External edge detection on the synchronised level.
    // The previous level resets low like the idle pin, so reset brings no false rise.
    logic ext_prev;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_level;
        end
    end

    wire ext_rise = ext_level && !ext_prev;
    wire ext_fall = !ext_level && ext_prev;

    // Falling-edge arming: a fresh start must see a fall before counting a rise.
    // A write to either count byte always wins over a fall in the same cycle.
    timer_pkg::edge_arm_e arm;
    timer_pkg::edge_arm_e next_arm;

    // R10 falling edge before first count
    always_comb begin
        next_arm = arm;
        case (arm)
            timer_pkg::EDGE_DISARMED: begin
                if (ext_fall && !wr_count) begin
                    next_arm = timer_pkg::EDGE_ARMED;
                end
            end
            timer_pkg::EDGE_ARMED: begin
                if (wr_count || (!ctrl.timer_on && ext_level)) begin
                    next_arm = timer_pkg::EDGE_DISARMED;
                end
            end
            default: next_arm = timer_pkg::EDGE_DISARMED;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            arm <= timer_pkg::EDGE_DISARMED;
        end else begin
            arm <= next_arm;
        end
    end

    // R2 clock source choice
    wire ext_tick = ext_rise && (arm == timer_pkg::EDGE_ARMED);
    wire src_tick = ctrl.clock_source_select ? ext_tick : instr_tick;
    wire pre_in   = src_tick && run_enable && awake_ok;

    // The prescaler sees only qualified ticks, so a stopped or gated timer holds its phase.
    // R4 R5 hidden prescaler cleared by count writes
    logic count_tick;

    tick_prescaler #(
        .WIDTH (`PRESCALE_W)
    ) u_prescaler (
        .clk      (CLK),
        .rst_n    (rst_n),
        .clear    (wr_count),
        .tick_in  (pre_in),
        .select   (ctrl.prescale_select),
        .tick_out (count_tick)
    );

    // The flag is raised by the tick that wraps the count, not by the zero value itself.
    // R1 rollover detection
    wire rollover = count_tick && (count == `COUNT_ALL_ONES);

    // Count register: a byte write replaces that byte and cancels the tick,
    // so a write racing an increment leaves the written value, not a blend.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            count <= `RST_COUNT;
        end else if (wr_low) begin
            count <= {count[15:8], WDATA};
        end else if (wr_high) begin
            count <= {WDATA, count[7:0]};
        end else if (count_tick) begin
            count <= count + 16'h0001;
        end
    end

    // A read that meets a rollover in the same cycle leaves the flag set, so no event is lost.
    // R13 sticky flag, set wins over the clearing read
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rollover_flag <= 1'b0;
        end else if (rollover) begin
            rollover_flag <= 1'b1;
        end else if (rd_status) begin
            rollover_flag <= 1'b0;
        end
    end

    // Configuration registers.
    // Each register changes only through its own decoded write strobe.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl                   <= timer_pkg::timer_control_s'(`RST_TIMER_CONTROL);
            rollover_irq_enable    <= 1'b0;
            peripheral_irq_enable  <= 1'b0;
            global_irq_enable      <= 1'b0;
            comparator_two_control <= `RST_COMP_TWO_CONTROL;
        end else begin
            if (wr_ctrl) begin
                ctrl <= timer_pkg::timer_control_s'(WDATA);
            end
            if (wr_mask) begin
                rollover_irq_enable <= WDATA[`BIT_ROLLOVER];
            end
            if (wr_global) begin
                peripheral_irq_enable <= WDATA[`BIT_PERIPH_IRQ_EN];
                global_irq_enable     <= WDATA[`BIT_GLOBAL_IRQ_EN];
            end
            if (wr_comp) begin
                comparator_two_control <= WDATA;
            end
        end
    end

    // R13 all three enables gate the interrupt
    assign IRQ  = rollover_flag && rollover_irq_enable && peripheral_irq_enable
                  && global_irq_enable;
    // Wake ignores the global enable, so a sleeping core resumes even with interrupts off.
    // R12 wake needs no global enable
    assign WAKE = rollover_flag && rollover_irq_enable && peripheral_irq_enable;

    // Read mux; unmapped bits read zero.
    logic [7:0] read_mux;

    always_comb begin
        read_mux = 8'h00;
        if (ADDR == `OFS_TIMER_CONTROL) begin
            read_mux = ctrl;
        end else if (ADDR == `OFS_COUNT_LOW_BYTE) begin
            read_mux = count[7:0];
        end else if (ADDR == `OFS_COUNT_HIGH_BYTE) begin
            read_mux = count[15:8];
        end else if (ADDR == `OFS_IRQ_STATUS) begin
            read_mux[`BIT_ROLLOVER] = rollover_flag;
        end else if (ADDR == `OFS_IRQ_MASK) begin
            read_mux[`BIT_ROLLOVER] = rollover_irq_enable;
        end else if (ADDR == `OFS_IRQ_GLOBAL) begin
            read_mux[`BIT_PERIPH_IRQ_EN] = peripheral_irq_enable;
            read_mux[`BIT_GLOBAL_IRQ_EN] = global_irq_enable;
        end else if (ADDR == `OFS_COMP_TWO_CONTROL) begin
            read_mux = comparator_two_control;
        end else begin
            read_mux = {4'h0, arm == timer_pkg::EDGE_ARMED, gate_true, run_enable,
                        lp_osc_eff};
        end
    end

    // Read data stand one cycle after the strobe, and only then.
    // Returning zero outside that slot keeps stale values off the read bus.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= RD ? read_mux : 8'h00;
        end
    end

endmodule : gated_sixteen_bit_timer

// ### src/timer_cfg.svh
// Offsets, field positions, reset values and timing counts of the gated 16-bit timer.
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// Register offsets on the plain register port.
`define ADDR_W               3
`define OFS_TIMER_CONTROL    3'h0
`define OFS_COUNT_LOW_BYTE   3'h1
`define OFS_COUNT_HIGH_BYTE  3'h2
`define OFS_IRQ_STATUS       3'h3
`define OFS_IRQ_MASK         3'h4
`define OFS_IRQ_GLOBAL       3'h5
`define OFS_COMP_TWO_CONTROL 3'h6
`define OFS_LIVE_STATE       3'h7

// Field positions.
`define BIT_ROLLOVER         0
`define BIT_PERIPH_IRQ_EN    0
`define BIT_GLOBAL_IRQ_EN    1
`define BIT_GATE_SOURCE_SEL  1

// Reset values.
`define RST_TIMER_CONTROL    8'h00
`define RST_COUNT            16'h0000
`define RST_COMP_TWO_CONTROL 8'h00

// Count limits and instruction clock division (Fosc/4).
`define COUNT_ALL_ONES       16'hffff
`define INSTR_DIV            4
`define PRESCALE_W           3

`endif

// ### src/timer_pkg.sv
// Types shared by the gated 16-bit timer design.
package timer_pkg;

    // Control register layout, bit 7 down to bit 0.
    typedef struct packed {
        logic       gate_polarity;
        logic       gate_enable;
        logic [1:0] prescale_select;
        logic       lp_osc_enable;
        logic       sync_disable;
        logic       clock_source_select;
        logic       timer_on;
    } timer_control_s;

    // Whether a rising external edge may count yet.
    typedef enum logic {
        EDGE_DISARMED = 1'b0,
        EDGE_ARMED    = 1'b1
    } edge_arm_e;

endpackage : timer_pkg

// ### src/tick_prescaler.sv
// Divides a stream of count ticks by 1, 2, 4 or 8 with a clearable hidden counter.
`include "timer_cfg.svh"

module tick_prescaler #(
    parameter int WIDTH = `PRESCALE_W
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clear,
    input  wire logic       tick_in,
    input  wire logic [1:0] select,
    output logic            tick_out
);

    // Dividing by eight needs three bits of hidden count, so narrower values are refused.
    if (WIDTH < 3) begin : g_width_check
        $error("tick_prescaler needs at least three bits to divide by eight");
    end

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] limit;

    // The last count value of each ratio; 00 passes every tick.
    assign limit    = WIDTH'((1 << select) - 1);
    assign tick_out = tick_in && (count == limit);

    // Clear wins over a tick so a count write always restarts the division.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (tick_in) begin
            count <= tick_out ? '0 : count + 1'b1;
        end
    end

endmodule : tick_prescaler

// ### testbench/timer_checker.sv
// Port-level assertions for the gated 16-bit timer, bound to its top module.
`include "timer_cfg.svh"

module timer_checker (
    input wire logic               CLK,
    input wire logic               ARST_N,
    input wire logic [`ADDR_W-1:0] ADDR,
    input wire logic [7:0]         WDATA,
    input wire logic               WR,
    input wire logic               RD,
    input wire logic [7:0]         RDATA,
    input wire logic               LP_OSC_ALLOWED,
    input wire logic               LP_OSC_RUN,
    input wire logic               IRQ,
    input wire logic               WAKE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    // Steps of a control write followed by its readback.
    sequence s_quiet;
        !WR && !RD;
    endsequence
    sequence s_ctrl_rd;
        RD && ADDR == `OFS_TIMER_CONTROL;
    endsequence

    // Read data stand only in the slot after a read strobe.
    property p_rdata_idle;
        !$past(RD) |-> RDATA == 8'h00;
    endproperty
    property p_ctrl_back;
        logic [7:0] d;
        (WR && ADDR == `OFS_TIMER_CONTROL, d = WDATA) ##1 s_quiet ##1 s_ctrl_rd |=> RDATA == d;
    endproperty
    // The core interrupt needs everything the wake needs plus the global enable.
    property p_irq_wake;
        IRQ |-> WAKE;
    endproperty
    property p_lp_allowed;
        LP_OSC_RUN |-> LP_OSC_ALLOWED;
    endproperty
    property p_lp_write;
        WR && ADDR == `OFS_TIMER_CONTROL |=> LP_OSC_RUN == ($past(WDATA[3]) && LP_OSC_ALLOWED);
    endproperty
    // A pending rollover only goes away through a status read or a register write.
    property p_wake_sticky;
        $fell(WAKE) |-> $past(WR) || ($past(RD) && $past(ADDR) == `OFS_IRQ_STATUS);
    endproperty
    property p_global_off;
        WR && ADDR == `OFS_IRQ_GLOBAL && !WDATA[`BIT_GLOBAL_IRQ_EN] |=> !IRQ;
    endproperty
    property p_mask_off;
        WR && ADDR == `OFS_IRQ_MASK && !WDATA[`BIT_ROLLOVER] |=> !WAKE;
    endproperty

    a_rdata_idle: assert property (p_rdata_idle) else $error("read data out of slot");
    a_ctrl_back: assert property (p_ctrl_back) else $error("control readback wrong");
    a_irq_wake: assert property (p_irq_wake) else $error("irq without wake");
    a_lp_allowed: assert property (p_lp_allowed) else $error("osc runs unallowed");
    a_lp_write: assert property (p_lp_write) else $error("osc enable not applied");
    a_wake_sticky: assert property (p_wake_sticky) else $error("flag lost by itself");
    a_global_off: assert property (p_global_off) else $error("irq with global off");
    a_mask_off: assert property (p_mask_off) else $error("wake with mask off");
endmodule : timer_checker

bind gated_sixteen_bit_timer timer_checker u_chk (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LP_OSC_ALLOWED(LP_OSC_ALLOWED),
    .LP_OSC_RUN(LP_OSC_RUN), .IRQ(IRQ), .WAKE(WAKE));

// ### testbench/count_source.sv
// Far-side model: bursts of external count clock and a free-running oscillator.
module count_source (
    input  wire logic clk,
    input  wire logic run,
    output logic      ext_clk,
    output logic      lp_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase;
    logic [1:0] lp_phase;

    initial begin
        phase = 2'h0;
        lp_phase = 2'h0;
        ext_clk = 1'b0;
        lp_clk = 1'b0;
    end

    // The pin rests low between bursts, so a stopped source never looks like a held edge.
    always @(posedge clk) begin
        phase <= run ? phase + 2'h1 : 2'h0;
        ext_clk <= run && (phase == 2'h3) ? ~ext_clk : (run ? ext_clk : 1'b0);
        lp_phase <= (lp_phase == 2'h2) ? 2'h0 : lp_phase + 2'h1;
        lp_clk <= (lp_phase == 2'h2) ? ~lp_clk : lp_clk;
    end
endmodule : count_source

// ### testbench/gated_sixteen_bit_timer_test.sv
// Self-checking bench for the gated 16-bit timer.
`include "timer_cfg.svh"

module gated_sixteen_bit_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic               CLK = 1'b0;
    logic               ARST_N = 1'b0;
    logic [`ADDR_W-1:0] ADDR = '0;
    logic [7:0]         WDATA = 8'h00;
    logic               WR = 1'b0;
    logic               RD = 1'b0;
    logic [7:0]         RDATA;
    logic               gpin = 1'b0;
    logic               comp = 1'b0;
    logic               sleep = 1'b0;
    logic               allowed = 1'b0;
    logic               erun = 1'b0;
    logic               rd_d = 1'b0;
    logic               ext_clk;
    logic               lp_clk;
    logic               LP_OSC_RUN;
    logic               IRQ;
    logic               WAKE;
    logic [7:0]         r;
    logic [7:0]         q;
    logic [15:0]        note;
    logic [15:0]        notes[$];
    int                 n_mismatch = 0;
    int                 checked = 0;
    // Case table: control, misc (b0 comp select, b1 pin, b2 comp, b3 sleep, b4 burst), count.
    logic [31:0]        cases [8] = '{32'hc1000000, 32'h41002001, 32'hc1052001, 32'h05002001,
                                      32'h00000000, 32'h03100f01, 32'h07180f01, 32'h03180000};

    always #50 CLK = ~CLK;

    gated_sixteen_bit_timer dut (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .EXT_COUNT_IN(ext_clk), .GATE_PIN(gpin),
        .COMP_TWO_OUT(comp), .LP_OSC_IN(lp_clk), .LP_OSC_ALLOWED(allowed), .SLEEP(sleep),
        .LP_OSC_RUN(LP_OSC_RUN), .IRQ(IRQ), .WAKE(WAKE));
    count_source far (.clk(CLK), .run(erun), .ext_clk(ext_clk), .lp_clk(lp_clk));

    // Compare within a tolerance; the count window may catch one tick more or less.
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] t,
                         input logic [7:0] s);
        checked++;
        if ((({1'b0, s} + t >= e) && ({1'b0, s} <= {1'b0, e} + t)) !== 1'b1) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr

    // A read leaves its expected byte and tolerance in the queue for the monitor.
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] t);
        notes.push_back({t, e});
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
    endtask : rd

    task automatic run_case(input logic [31:0] c);
        wr(`OFS_COMP_TWO_CONTROL, {6'h00, c[16], 1'b0});
        gpin <= c[17];
        comp <= c[18];
        sleep <= c[19];
        wr(`OFS_COUNT_LOW_BYTE, 8'h00);
        wr(`OFS_COUNT_HIGH_BYTE, 8'h00);
        wr(`OFS_TIMER_CONTROL, c[31:24]);
        erun <= c[20];
        repeat (128) @(posedge CLK);
        erun <= 1'b0;
        sleep <= 1'b0;
        wr(`OFS_TIMER_CONTROL, 8'h00);
        rd(`OFS_COUNT_LOW_BYTE, c[15:8], c[7:0]);
        rd(`OFS_COUNT_HIGH_BYTE, 8'h00, 8'h00);
    endtask : run_case

    // Levels are read a little after the launching edge, once they have settled;
    // w picks the output: 0 oscillator run, 1 interrupt, 2 wake.
    task automatic lvl(input string n, input logic e, input logic [1:0] w);
        #10;
        check(n, {7'h00, e}, 8'h00,
              {7'h00, (w == 2'h0) ? LP_OSC_RUN : ((w == 2'h1) ? IRQ : WAKE)});
    endtask : lvl

    task automatic print_verdict();
        if (n_mismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // Monitor: each read result is taken in the slot after its strobe.
    always @(posedge CLK) begin
        if (rd_d) begin
            note = notes.pop_front();
            check("RDATA", note[7:0], note[15:8], RDATA);
        end
        rd_d <= RD;
    end

    // Watchdog well beyond the fewer than two thousand cycles the sequence needs.
    initial begin
        #2000000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'hc29de59d));
        repeat (8) @(posedge CLK);
        ARST_N <= 1'b1;
        repeat (2) @(posedge CLK);
        rd(`OFS_TIMER_CONTROL, `RST_TIMER_CONTROL, 8'h00);
        rd(`OFS_COMP_TWO_CONTROL, `RST_COMP_TWO_CONTROL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            r = 8'($urandom()) & 8'hfe;
            wr(`OFS_TIMER_CONTROL, r);
            rd(`OFS_TIMER_CONTROL, r, 8'h00);
        end
        q = 8'($urandom());
        wr(`OFS_COUNT_LOW_BYTE, q);
        wr(`OFS_COUNT_HIGH_BYTE, ~q);
        wr(`OFS_IRQ_STATUS, 8'hff);
        rd(`OFS_COUNT_LOW_BYTE, q, 8'h00);
        rd(`OFS_COUNT_HIGH_BYTE, ~q, 8'h00);
        // Disarmed after the count writes, timer off, gate pin low against the last polarity.
        rd(`OFS_LIVE_STATE, {5'h00, ~r[7], 2'h0}, 8'h00);
        allowed <= 1'b1;
        wr(`OFS_TIMER_CONTROL, 8'h08);
        lvl("LP_OSC_RUN", 1'b1, 2'h0);
        @(posedge CLK);
        allowed <= 1'b0;
        lvl("LP_OSC_RUN", 1'b0, 2'h0);
        // Rollover from all ones with software clearing the flag before enabling.
        rd(`OFS_IRQ_STATUS, 8'h00, 8'h00);
        wr(`OFS_COUNT_LOW_BYTE, 8'hfe);
        wr(`OFS_COUNT_HIGH_BYTE, 8'hff);
        wr(`OFS_IRQ_MASK, 8'h01);
        wr(`OFS_IRQ_GLOBAL, 8'h03);
        wr(`OFS_TIMER_CONTROL, 8'h01);
        repeat (20) @(posedge CLK);
        wr(`OFS_TIMER_CONTROL, 8'h00);
        lvl("IRQ", 1'b1, 2'h1);
        wr(`OFS_IRQ_GLOBAL, 8'h01);
        lvl("IRQ", 1'b0, 2'h1);
        lvl("WAKE", 1'b1, 2'h2);
        wr(`OFS_IRQ_MASK, 8'h00);
        lvl("WAKE", 1'b0, 2'h2);
        wr(`OFS_IRQ_MASK, 8'h01);
        lvl("WAKE", 1'b1, 2'h2);
        rd(`OFS_IRQ_STATUS, 8'h01, 8'h00);
        lvl("WAKE", 1'b0, 2'h2);
        rd(`OFS_IRQ_STATUS, 8'h00, 8'h00);
        rd(`OFS_COUNT_LOW_BYTE, 8'h03, 8'h01);
        rd(`OFS_COUNT_HIGH_BYTE, 8'h00, 8'h00);
        for (int p = 0; p < 4; p++) begin
            run_case({2'b00, 2'(p), 4'h1, 8'h00, 8'(32 >> p), 8'h01});
        end
        for (int i = 0; i < 8; i++) begin
            run_case(cases[i]);
        end
        repeat (3) @(posedge CLK);
        print_verdict();
    end
endmodule : gated_sixteen_bit_timer_test
